// file: logic/tsq_step_queue.v
// Step queue and step pointer registers of the trigger sequencer.
// Assumes one synchronous clock, async reset, and a plain register port.
`timescale 1ns/1ps
`include "tsq_map.vh"

// Contract
// - Five-bit step pointer in low bits
// - Writes ignored while enable and run set
// - Pointer bits 15-5 read zero
// - Eight words, even byte low, odd high
// - Queue words untouched by any reset
module tsq_step_queue (
	input wire i_clock,
	input wire i_rst,
	input wire [`TSQ_ADDR_W-1:0] i_addr,
	input wire [`TSQ_DATA_W-1:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire i_sequencer_enable_bit,
	input wire i_sequencer_run_bit,
	output reg [`TSQ_DATA_W-1:0] o_rdata,
	output wire [`TSQ_PTR_W-1:0] o_step_queue_pointer,
	output wire [`TSQ_BYTE_W-1:0] o_active_step_byte
);

	// ****************************************
	// Address decode
	// ****************************************

	// Top address bit clear selects the queue
	function is_queue;
		input [`TSQ_ADDR_W-1:0] a;
		begin
			is_queue = (a[`TSQ_ADDR_QSEL] == `TSQ_QSEL_QUEUE);
		end
	endfunction

	// Pointer slot
	function is_pointer;
		input [`TSQ_ADDR_W-1:0] a;
		begin
			is_pointer = (a == `TSQ_OFS_PTR);
		end
	endfunction

	// Queue word index in the low address bits
	function [`TSQ_IDX_W-1:0] word_index;
		input [`TSQ_ADDR_W-1:0] a;
		begin
			word_index = a[`TSQ_IDX_W-1:0];
		end
	endfunction

	// One-hot enable for a queue word
	function [`TSQ_WORDS-1:0] word_hit;
		input [`TSQ_IDX_W-1:0] idx;
		begin
			word_hit = `TSQ_WE_ONE << idx;
		end
	endfunction

	// Write gate, shut while locked
	function write_open;
		input wr;
		input lk;
		begin
			write_open = wr & ~lk;
		end
	endfunction

	// ****************************************
	// Step helpers
	// ****************************************

	// Queue word that holds a step
	function [`TSQ_IDX_W-1:0] step_word;
		input [`TSQ_PTR_W-1:0] p;
		begin
			step_word = p[`TSQ_IDX_W:`TSQ_SEL_LSB];
		end
	endfunction

	// Even step low byte, odd step high byte
	function [`TSQ_BYTE_W-1:0] step_byte;
		input [`TSQ_DATA_W-1:0] w;
		input odd;
		begin
			if (odd) begin
				step_byte = w[`TSQ_DATA_W-1:`TSQ_BYTE_W];
			end else begin
				step_byte = w[`TSQ_BYTE_W-1:0];
			end
		end
	endfunction

	// Pointer as seen on the register port
	function [`TSQ_DATA_W-1:0] pointer_view;
		input [`TSQ_PTR_W-1:0] p;
		begin
			pointer_view = {`TSQ_PTR_PAD, p};
		end
	endfunction

	// Queue word by index, for read port and active step
	function [`TSQ_DATA_W-1:0] pick_word;
		input [`TSQ_IDX_W-1:0] idx;
		begin
			case (idx)
				`TSQ_W0: begin
					pick_word = step_queue_word[`TSQ_W0];
				end
				`TSQ_W1: begin
					pick_word = step_queue_word[`TSQ_W1];
				end
				`TSQ_W2: begin
					pick_word = step_queue_word[`TSQ_W2];
				end
				`TSQ_W3: begin
					pick_word = step_queue_word[`TSQ_W3];
				end
				`TSQ_W4: begin
					pick_word = step_queue_word[`TSQ_W4];
				end
				`TSQ_W5: begin
					pick_word = step_queue_word[`TSQ_W5];
				end
				`TSQ_W6: begin
					pick_word = step_queue_word[`TSQ_W6];
				end
				`TSQ_W7: begin
					pick_word = step_queue_word[`TSQ_W7];
				end
				default: begin
					pick_word = `TSQ_DATA_ZERO;
				end
			endcase
		end
	endfunction

	// ****************************************
	// Storage and nets
	// ****************************************

	reg [`TSQ_PTR_W-1:0] ptr_r;
	reg [`TSQ_PTR_W-1:0] ptr_nxt;
	reg [`TSQ_DATA_W-1:0] step_queue_word [0:`TSQ_WORDS-1];
	reg [`TSQ_WORDS-1:0] word_we;
	reg [`TSQ_DATA_W-1:0] rdata_nxt;
	wire locked;
	wire wr_open;
	wire que_sel;
	wire ptr_sel;
	wire ptr_we;
	wire [`TSQ_IDX_W-1:0] widx;
	wire [`TSQ_IDX_W-1:0] act_idx;
	wire act_odd;
	wire [`TSQ_DATA_W-1:0] act_word;

	assign que_sel = is_queue(i_addr);
	assign ptr_sel = is_pointer(i_addr);
	assign ptr_we = wr_open & ptr_sel;
	assign widx = word_index(i_addr);

	// ****************************************
	// Write lock
	// ****************************************

	// Set while the sequencer executes steps
	assign locked = i_sequencer_enable_bit & i_sequencer_run_bit;
	assign wr_open = write_open(i_wr, locked);

	// ****************************************
	// Step pointer
	// ****************************************

	// Software write, unless locked
	always @* begin
		ptr_nxt = ptr_r;
		if (ptr_we) begin
			ptr_nxt = i_wdata[`TSQ_PTR_W-1:0];
		end
	end

	// Async clear; the queue has no reset
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ptr_r <= `TSQ_PTR_RST;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	// ****************************************
	// Queue write enables
	// ****************************************

	// One word at most per write
	always @* begin
		word_we = `TSQ_WE_NONE;
		if (wr_open && que_sel) begin
			word_we = word_hit(widx);
		end
	end

	// ****************************************
	// Queue storage, no reset
	// ****************************************

	// Word 0: steps 0 and 1
	always @(posedge i_clock) begin
		if (word_we[`TSQ_W0]) begin
			step_queue_word[`TSQ_W0] <= i_wdata;
		end
	end

	// Word 1: steps 2 and 3
	always @(posedge i_clock) begin
		if (word_we[`TSQ_W1]) begin
			step_queue_word[`TSQ_W1] <= i_wdata;
		end
	end

	// Word 2: steps 4 and 5
	always @(posedge i_clock) begin
		if (word_we[`TSQ_W2]) begin
			step_queue_word[`TSQ_W2] <= i_wdata;
		end
	end

	// Word 3: steps 6 and 7
	always @(posedge i_clock) begin
		if (word_we[`TSQ_W3]) begin
			step_queue_word[`TSQ_W3] <= i_wdata;
		end
	end

	// Word 4: steps 8 and 9
	always @(posedge i_clock) begin
		if (word_we[`TSQ_W4]) begin
			step_queue_word[`TSQ_W4] <= i_wdata;
		end
	end

	// Word 5: steps 10 and 11
	always @(posedge i_clock) begin
		if (word_we[`TSQ_W5]) begin
			step_queue_word[`TSQ_W5] <= i_wdata;
		end
	end

	// Word 6: steps 12 and 13
	always @(posedge i_clock) begin
		if (word_we[`TSQ_W6]) begin
			step_queue_word[`TSQ_W6] <= i_wdata;
		end
	end

	// Word 7: steps 14 and 15
	always @(posedge i_clock) begin
		if (word_we[`TSQ_W7]) begin
			step_queue_word[`TSQ_W7] <= i_wdata;
		end
	end

	// ****************************************
	// Read port
	// ****************************************

	// Zero unless a read is taken
	always @* begin
		rdata_nxt = `TSQ_DATA_ZERO;
		if (i_rd) begin
			if (que_sel) begin
				rdata_nxt = pick_word(widx);
			end else if (ptr_sel) begin
				rdata_nxt = pointer_view(ptr_r);
			end else begin
				rdata_nxt = `TSQ_DATA_ZERO;
			end
		end
	end

	// Stands one cycle after the read
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= `TSQ_DATA_ZERO;
		end else begin
			o_rdata <= rdata_nxt;
		end
	end

	// ****************************************
	// Active step
	// ****************************************

	// Pointer top bit takes no part in word select
	assign act_idx = step_word(ptr_r);
	assign act_odd = ptr_r[`TSQ_ODD_BIT];
	assign act_word = pick_word(act_idx);
	assign o_active_step_byte = step_byte(act_word, act_odd);
	assign o_step_queue_pointer = ptr_r;

endmodule

// file: logic/tsq_map.vh
// Register map and field constants for the trigger sequencer step queue.
// Assumes a plain register port with word-indexed addresses.
`ifndef TSQ_MAP_VH
`define TSQ_MAP_VH

`define TSQ_ADDR_W 4
`define TSQ_DATA_W 16
`define TSQ_PTR_W 5
`define TSQ_BYTE_W 8
`define TSQ_WORDS 8
`define TSQ_IDX_W 3
`define TSQ_OFS_PTR 4'h8
`define TSQ_OFS_QUE0 4'h0
`define TSQ_PTR_RST 5'h00
`define TSQ_PTR_PAD 11'h000
`define TSQ_DATA_ZERO 16'h0000
`define TSQ_ADDR_QSEL 3
`define TSQ_QSEL_QUEUE 1'h0
`define TSQ_SEL_LSB 1
`define TSQ_ODD_BIT 0
`define TSQ_WE_NONE 8'h00
`define TSQ_WE_ONE 8'h01
`define TSQ_W0 3'h0
`define TSQ_W1 3'h1
`define TSQ_W2 3'h2
`define TSQ_W3 3'h3
`define TSQ_W4 3'h4
`define TSQ_W5 3'h5
`define TSQ_W6 3'h6
`define TSQ_W7 3'h7

`endif

// file: dv/tsq_checker.sv
// Checker for the step queue register block.
// Assumes it is bound to tsq_step_queue.
`timescale 1ns/1ps
module tsq_checker(input wire i_clock,input wire i_rst,input wire [3:0] i_addr,
	input wire [15:0] i_wdata,input wire i_wr,input wire i_rd,input wire i_sequencer_enable_bit,
	input wire i_sequencer_run_bit,input wire [15:0] o_rdata,input wire [4:0] o_step_queue_pointer);
	wire lk=i_sequencer_enable_bit&&i_sequencer_run_bit;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	chk_ptr_write: assert property(i_wr&&i_addr==8&&!lk|=>o_step_queue_pointer==$past(i_wdata[4:0]))
		else $error("pointer write lost");
	chk_write_lock: assert property(i_wr&&lk|=>$stable(o_step_queue_pointer))
		else $error("locked pointer changed");
	chk_pad_zero: assert property(i_rd&&i_addr==8|=>o_rdata[15:5]==0)
		else $error("pointer pad not zero");
	chk_ptr_read: assert property(i_rd&&i_addr==8|=>o_rdata[4:0]==$past(o_step_queue_pointer))
		else $error("pointer read wrong");
	chk_rdata_idle: assert property(!i_rd|=>o_rdata==0)
		else $error("read data not idle");
	chk_ptr_reset: assert property(@(posedge i_clock) disable iff (1'b0) i_rst|->o_step_queue_pointer==0)
		else $error("pointer not cleared");
	cover property(i_wr&&i_addr==8&&!lk);
	cover property(i_wr&&lk);
	cover property(i_rd&&i_addr<8);
endmodule
bind tsq_step_queue tsq_checker i_chk(.*);

// file: dv/testbench.sv
// Random register traffic against a reference copy.
// Assumes tsq_step_queue with word addresses.
`timescale 1ns/1ps
module testbench;
reg i_clock=0,i_rst=0,i_wr=0,i_rd=0,en=0,run=0;reg [3:0] a=0;reg [15:0] d=0,e,q[8];reg [4:0] p=0;
wire [15:0] rd;wire [4:0] op;wire [7:0] ab;integer seed=97,n_mismatch=0,n_checks=0,k;
always #2 i_clock=~i_clock;
tsq_step_queue i_dut(.i_clock(i_clock),.i_rst(i_rst),.i_addr(a),.i_wdata(d),.i_wr(i_wr),.i_rd(i_rd),
	.i_sequencer_enable_bit(en),.i_sequencer_run_bit(run),.o_rdata(rd),.o_step_queue_pointer(op),
	.o_active_step_byte(ab));
task chk(input [8*5-1:0] nm,input [15:0] s,input [15:0] x);begin n_checks=n_checks+1;
	if(s!==x)begin n_mismatch=n_mismatch+1;$display("[FAIL] %0s exp %h got %h",nm,x,s);end end endtask
task xop(input m,input w,input [3:0] x,input [15:0] v);reg ee,rr;begin
	ee=m&$random(seed);rr=m&$random(seed);@(posedge i_clock);a<=x;d<=v;i_wr<=w;i_rd<=!w;en<=ee;run<=rr;
	e=x<8?q[x[2:0]]:x==8?{11'h0,p}:16'h0;
	if(w&&!(ee&&rr))begin if(x<8)q[x[2:0]]=v;if(x==8)p=v[4:0];end
	@(posedge i_clock);i_wr<=0;i_rd<=0;#1 if(!w)chk("rdata",rd,e);
	chk("step",{8'h0,ab},{8'h0,p[0]?q[p[3:1]][15:8]:q[p[3:1]][7:0]});
	chk("ptr",{11'h0,op},{11'h0,p});end endtask
task results;begin $display("checks %0d mismatches %0d",n_checks,n_mismatch);
	if(n_mismatch==0&&n_checks>0)$display("*** PASS ***");else $display("*** FAIL ***");$finish;end endtask
initial begin i_rst<=1;repeat(20)@(posedge i_clock);i_rst<=0;
	for(k=0;k<8;k=k+1)xop(0,1,k,$random(seed));
	for(k=0;k<400;k=k+1)xop(1,$random(seed),$random(seed),$random(seed));
	@(posedge i_clock);i_rst<=1;@(posedge i_clock);i_rst<=0;p=0;
	for(k=0;k<9;k=k+1)xop(0,0,k,0);
	results;end
initial begin #100000;n_mismatch=n_mismatch+1;results;end
endmodule
